// ---- pwcl_pkg.sv ----
// How it works
// - Only one output driver type enabled
// - Emitter type, enable low: both legs float
// - Differential type, enable low: outputs float
// - Enable pin ignored outside normal state
// - Pattern 001100 enters programming mode
// - Short high is zero, long high one
// - Delayed pin copy strobes undelayed pin
// - Pulse of 16 ms aborts entry sequence
// - Write words, idle, then jump to store
// - Word writes touch only the RAM copy
// - Address code then inverted payload bits
// - Exit jump returns to normal operation
// - Readback: first pin clock loads shifter
// - Later clocks shift 59 bits out
// - 61st edge restores normal clock output
// - Readback sends bit zero first
// - Pattern 111011 enters readback mode
// - Word latched right after its last symbol
// - Jump codes enter store, with or without lock
// - Code 111 0000 0000 or undefined exits
package pwcl_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int SYM_RATE_KHZ = 70;
    // Strobe at half a nominal period, between 0.2 t and 0.8 t at any legal rate
    localparam int STROBE_NS = 1000000 / (2 * SYM_RATE_KHZ);
    localparam int STROBE_CYC = STROBE_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_MS = 16;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int DLY_W = 11;
    localparam int TO_W = 23;
    // ----------------------------------------
    // Command layout
    // ----------------------------------------
    localparam int ENTRY_SYMS = 6;
    localparam int CMD_SYMS = 11;
    localparam logic [5:0] PAT_PROG = 6'h0C;
    localparam logic [5:0] PAT_READBACK = 6'h3B;
    localparam logic [2:0] ADDR_JUMP = 3'h7;
    localparam logic [7:0] JUMP_STORE = 8'hF0;
    localparam logic [7:0] JUMP_STORE_LOCK = 8'h55;
    localparam logic [7:0] JUMP_EXIT = 8'h00;
    localparam int NUM_WORDS = 6;
    localparam int DRV_SEL_BIT = 6;
    localparam int RB_BITS = 59;
    localparam logic [5:0] RB_LAST_EDGE = 6'h3C;
    localparam logic [2:0] REV_ID = 3'h0; // Arbitrary value
    localparam logic [5:0][7:0] WORDS_RESET = 48'h0;
    // ----------------------------------------
    // Link states, gray along the usual path
    // ----------------------------------------
    typedef enum logic [2:0] {
        M_NORMAL = 3'h0,
        M_PROG = 3'h1,
        M_STORE = 3'h3,
        M_STORE_LOCK = 3'h2,
        M_READBACK = 3'h6
    } pwcl_mode_type;
endpackage

// ---- pwcl_sym_decoder.sv ----
`timescale 1ns/10ps
`default_nettype none
module pwcl_sym_decoder #(
    parameter int TIMEOUT_CYC = pwcl_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Programming pin, asynchronous
    input wire logic progPin,
    // Decoded symbols
    output logic symValid,
    output logic symBit,
    output logic pinRise,
    output logic timeOut
);
    import pwcl_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic progPinDelayed;
        logic [DLY_W-1:0] dlyCnt;
        logic [TO_W-1:0] toCnt;
        logic toFired;
        logic symValid;
        logic symBit;
        logic pinRise;
        logic timeOut;
    } pwcl_dec_type;

    pwcl_dec_type dec_reg, dec_next;

    // ----------------------------------------
    // Pulse width measurement
    // ----------------------------------------
    // Delayed copy rises a fixed time after the pin, its edge samples the pin
    always_comb begin
        dec_next = dec_reg;
        dec_next.sync1 = progPin;
        dec_next.sync2 = dec_reg.sync1;
        dec_next.prev = dec_reg.sync2;
        dec_next.symValid = 1'b0;
        dec_next.pinRise = 1'b0;
        dec_next.timeOut = 1'b0;
        if (dec_reg.sync2 && !dec_reg.prev) begin
            dec_next.pinRise = 1'b1;
            dec_next.dlyCnt = DLY_W'(STROBE_CYC);
        end else if (dec_reg.dlyCnt != '0) begin
            dec_next.dlyCnt = dec_reg.dlyCnt - 1'b1;
            if (dec_reg.dlyCnt == DLY_W'(1)) begin
                dec_next.progPinDelayed = 1'b1;
                dec_next.symValid = 1'b1;
                dec_next.symBit = dec_reg.sync2;
            end
        end else if (!dec_reg.sync2) begin
            dec_next.progPinDelayed = 1'b0;
        end
        // Any level held too long fires once until the next edge
        if (dec_reg.sync2 != dec_reg.prev) begin
            dec_next.toCnt = '0;
            dec_next.toFired = 1'b0;
        end else if (!dec_reg.toFired) begin
            dec_next.toCnt = dec_reg.toCnt + 1'b1;
            if (dec_reg.toCnt == TO_W'(TIMEOUT_CYC - 1)) begin
                dec_next.timeOut = 1'b1;
                dec_next.toFired = 1'b1;
            end
        end
        if (!rst_n) begin
            dec_next = '0;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        dec_reg <= dec_next;
    end

    assign symValid = dec_reg.symValid;
    assign symBit = dec_reg.symBit;
    assign pinRise = dec_reg.pinRise;
    assign timeOut = dec_reg.timeOut;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_sym_strobe: assert property ($rose(dec_reg.progPinDelayed) |->
        symValid && symBit == $past(dec_reg.sync2))
        else $error("symbol not sampled at delayed edge");
    a_timeout_wait: assert property (timeOut |->
        $past(dec_reg.toCnt) == TO_W'(TIMEOUT_CYC - 1))
        else $error("time-out before full count");
endmodule
`default_nettype wire

// ---- pwcl_readback.sv ----
`timescale 1ns/10ps
`default_nettype none
module pwcl_readback (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control from the link
    input wire logic start,
    input wire logic pinRise,
    input wire logic [pwcl_pkg::RB_BITS-1:0] loadData,
    // Stream
    output logic active,
    output logic bitOut,
    output logic done
);
    import pwcl_pkg::*;

    typedef struct packed {
        logic active;
        logic [5:0] edgeCnt;
        logic [RB_BITS-1:0] shifter;
        logic bitOut;
        logic done;
    } pwcl_rb_type;

    pwcl_rb_type rb_reg, rb_next;

    // ----------------------------------------
    // Edge counting and shifting
    // ----------------------------------------
    always_comb begin
        rb_next = rb_reg;
        rb_next.done = 1'b0;
        if (start) begin
            rb_next.active = 1'b1;
            rb_next.edgeCnt = '0;
        end else if (rb_reg.active && pinRise) begin
            rb_next.edgeCnt = rb_reg.edgeCnt + 1'b1;
            if (rb_reg.edgeCnt == '0) begin
                rb_next.shifter = loadData;
            end else if (rb_reg.edgeCnt < RB_LAST_EDGE) begin
                rb_next.bitOut = rb_reg.shifter[0];
                rb_next.shifter = rb_reg.shifter >> 1;
            end else begin
                rb_next.active = 1'b0;
                rb_next.done = 1'b1;
            end
        end
        if (!rst_n) begin
            rb_next = '0;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        rb_reg <= rb_next;
    end

    assign active = rb_reg.active;
    assign bitOut = rb_reg.bitOut;
    assign done = rb_reg.done;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_rb_load: assert property (rb_reg.active && pinRise && rb_reg.edgeCnt == 6'h00
        && !start |=> rb_reg.shifter == $past(loadData))
        else $error("readback load missed");
    a_rb_first: assert property (rb_reg.active && pinRise && rb_reg.edgeCnt == 6'h01
        && !start |=> bitOut == $past(rb_reg.shifter[0]))
        else $error("first bit out wrong");
    a_rb_end: assert property (rb_reg.active && pinRise && rb_reg.edgeCnt == 6'h3C
        && !start |=> done && !active)
        else $error("readback did not end on edge 61");
endmodule
`default_nettype wire

// ---- pwcl_link.sv ----
`timescale 1ns/10ps
`default_nettype none
module pwcl_link #(
    parameter int TIMEOUT_CYC = pwcl_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Device pins
    input wire logic progPin,
    input wire logic cePin,
    // Synthesised clock level from the PLL
    input wire logic pllClk,
    // Clock output pin and driver controls
    output logic clkOutPin,
    output logic lvdsOe_n,
    output logic eclOe_n,
    output logic powerDown,
    // Configuration view
    output logic [47:0] cfgRam,
    output pwcl_pkg::pwcl_mode_type linkMode
);
    import pwcl_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        pwcl_mode_type mode;
        logic [CMD_SYMS-2:0] hist;
        logic [3:0] symCnt;
        logic [NUM_WORDS-1:0][7:0] ram;
        logic [NUM_WORDS-1:0][7:0] nvm;
        logic nvWritten;
        logic nvLock;
        logic rbStart;
        logic ceSync1;
        logic ceSync2;
        logic pllSync1;
        logic pllSync2;
        logic clkOutPin;
        logic lvdsOe_n;
        logic eclOe_n;
        logic powerDown;
    } pwcl_top_type;

    pwcl_top_type top_reg, top_next;

    logic symValid;
    logic symBit;
    logic pinRise;
    logic timeOut;
    logic rbActive;
    logic rbBit;
    logic rbDone;
    logic [RB_BITS-1:0] rbData;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Readback image, index is the order of leaving the pin
    function automatic logic [RB_BITS-1:0] rb_image(
        input logic [NUM_WORDS-1:0][7:0] words,
        input logic written,
        input logic locked
    );
        logic [RB_BITS-1:0] img;
        img = '0;
        for (int k = 0; k < 3; k++) begin
            img[k] = REV_ID[2-k];
        end
        for (int k = 0; k < 6; k++) begin
            img[3+k] = words[4][k];
        end
        img[9] = written;
        img[10] = locked;
        for (int w = 0; w < NUM_WORDS; w++) begin
            for (int k = 0; k < 8; k++) begin
                img[11+8*(5-w)+k] = words[w][7-k];
            end
        end
        return img;
    endfunction

    // Payload symbols arrive inverted, first symbol is the low bit
    function automatic logic [7:0] payload(input logic [7:0] syms);
        logic [7:0] d;
        d = '0;
        for (int k = 0; k < 8; k++) begin
            d[k] = ~syms[7-k];
        end
        return d;
    endfunction

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------
    pwcl_sym_decoder #(
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_dec (
        .clock(clock),
        .rst_n(rst_n),
        .progPin(progPin),
        .symValid(symValid),
        .symBit(symBit),
        .pinRise(pinRise),
        .timeOut(timeOut)
    );

    assign rbData = rb_image(top_reg.nvm, top_reg.nvWritten, top_reg.nvLock);

    pwcl_readback u_rb (
        .clock(clock),
        .rst_n(rst_n),
        .start(top_reg.rbStart),
        .pinRise(pinRise),
        .loadData(rbData),
        .active(rbActive),
        .bitOut(rbBit),
        .done(rbDone)
    );

    // ----------------------------------------
    // Link state machine and outputs
    // ----------------------------------------
    always_comb begin
        logic [CMD_SYMS-1:0] cmd;
        logic [2:0] addr;
        logic effEnable;
        logic eclSel;
        cmd = {top_reg.hist, symBit};
        addr = {cmd[8], cmd[9], cmd[10]};
        effEnable = 1'b0;
        eclSel = 1'b0;
        top_next = top_reg;
        top_next.rbStart = 1'b0;
        top_next.ceSync1 = cePin;
        top_next.ceSync2 = top_reg.ceSync1;
        top_next.pllSync1 = pllClk;
        top_next.pllSync2 = top_reg.pllSync1;
        if (symValid) begin
            top_next.hist = cmd[CMD_SYMS-2:0];
        end
        unique case (top_reg.mode)
            M_NORMAL: begin
                // Entry patterns are checked on a sliding six-symbol window
                if (timeOut) begin
                    top_next.symCnt = '0;
                end else if (symValid) begin
                    if (top_reg.symCnt == 4'(ENTRY_SYMS - 1)) begin
                        if (cmd[5:0] == PAT_PROG) begin
                            top_next.mode = M_PROG;
                            top_next.symCnt = '0;
                        end else if (cmd[5:0] == PAT_READBACK) begin
                            top_next.mode = M_READBACK;
                            top_next.rbStart = 1'b1;
                            top_next.symCnt = '0;
                        end
                    end else begin
                        top_next.symCnt = top_reg.symCnt + 1'b1;
                    end
                end
            end
            M_PROG, M_STORE, M_STORE_LOCK: begin
                // Delays between symbols are legal here, so no time-out
                if (symValid) begin
                    if (top_reg.symCnt == 4'(CMD_SYMS - 1)) begin
                        top_next.symCnt = '0;
                        if (addr == ADDR_JUMP) begin
                            if (top_reg.mode == M_PROG && cmd[7:0] == JUMP_STORE) begin
                                top_next.mode = M_STORE;
                            end else if (top_reg.mode == M_PROG
                                && cmd[7:0] == JUMP_STORE_LOCK) begin
                                top_next.mode = M_STORE_LOCK;
                            end else begin
                                top_next.mode = M_NORMAL;
                            end
                        end else if (top_reg.mode == M_PROG && addr < 3'(NUM_WORDS)) begin
                            top_next.ram[addr] = payload(cmd[7:0]);
                        end
                    end else begin
                        top_next.symCnt = top_reg.symCnt + 1'b1;
                    end
                end
                // A locked store is never rewritten
                if (top_reg.mode != M_PROG && !top_reg.nvLock) begin
                    top_next.nvm = top_reg.ram;
                    top_next.nvWritten = 1'b1;
                    top_next.nvLock = (top_reg.mode == M_STORE_LOCK);
                end
            end
            M_READBACK: begin
                // Pin is a plain clock here; symbols are ignored
                if (rbDone) begin
                    top_next.mode = M_NORMAL;
                    top_next.symCnt = '0;
                end
            end
            default: begin
                top_next.mode = M_NORMAL;
                top_next.symCnt = '0;
            end
        endcase
        // Enable pin has no say while the link is busy
        effEnable = top_reg.ceSync2 || (top_reg.mode != M_NORMAL);
        eclSel = top_reg.ram[0][DRV_SEL_BIT];
        top_next.powerDown = !effEnable;
        top_next.lvdsOe_n = !(effEnable && !eclSel);
        top_next.eclOe_n = !(effEnable && eclSel);
        top_next.clkOutPin = rbActive ? rbBit : top_reg.pllSync2;
        if (!rst_n) begin
            top_next = '0;
            top_next.mode = M_NORMAL;
            top_next.ram = WORDS_RESET;
            top_next.nvm = WORDS_RESET;
            top_next.lvdsOe_n = 1'b1;
            top_next.eclOe_n = 1'b1;
            top_next.powerDown = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        top_reg <= top_next;
    end

    // Outputs straight from the state register
    assign clkOutPin = top_reg.clkOutPin;
    assign lvdsOe_n = top_reg.lvdsOe_n;
    assign eclOe_n = top_reg.eclOe_n;
    assign powerDown = top_reg.powerDown;
    assign cfgRam = top_reg.ram;
    assign linkMode = top_reg.mode;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_one_driver: assert property (lvdsOe_n || eclOe_n)
        else $error("both drivers enabled");
    a_ecl_float: assert property (top_reg.mode == M_NORMAL && !top_reg.ceSync2
        && top_reg.ram[0][DRV_SEL_BIT] |=> eclOe_n && lvdsOe_n)
        else $error("emitter driver not floated");
    a_lvds_float: assert property (top_reg.mode == M_NORMAL && !top_reg.ceSync2
        && !top_reg.ram[0][DRV_SEL_BIT] |=> lvdsOe_n && powerDown)
        else $error("differential driver not floated");
    a_ce_ignored: assert property (top_reg.mode != M_NORMAL |=> !powerDown)
        else $error("power-down while link busy");
    a_prog_entry: assert property ($changed(top_reg.mode) && top_reg.mode == M_PROG |->
        $past(top_reg.mode) == M_NORMAL && $past(symValid)
        && $past({top_reg.hist[4:0], symBit}) == PAT_PROG)
        else $error("programming entered without pattern");
    a_ram_only: assert property (top_reg.mode == M_PROG || top_reg.mode == M_NORMAL
        |=> $stable(top_reg.nvm))
        else $error("store changed outside store states");
    a_timeout_abort: assert property (top_reg.mode == M_NORMAL && timeOut
        |=> top_reg.symCnt == 4'h0 && top_reg.mode == M_NORMAL)
        else $error("time-out did not abort entry");
    a_lock_holds: assert property (top_reg.nvLock |=> $stable(top_reg.nvm))
        else $error("locked store rewritten");
endmodule
`default_nettype wire

// ---- pwcl_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pwcl_host_model (
    // Clock
    input wire logic clock,
    // Programming pin
    output logic progPin
);
    // ----------------------------------------
    // Symbol timing, fastest legal rate
    // ----------------------------------------
    localparam int SYM_CYC = 3125;
    localparam int LONG_CYC = SYM_CYC * 4 / 5;
    localparam int SHORT_CYC = SYM_CYC - LONG_CYC;
    // Readback clock of 48 ns, pin rests low between clocks
    localparam int RB_HALF = 6;

    // Pin low at release of reset
    initial progPin = 1'b0;

    // Level held for a count of clocks, changed just after an edge
    task automatic hold(input logic level, input int cycles);
        progPin = level;
        repeat (cycles) @(posedge clock);
        #1;
    endtask

    // One pulse-width coded symbol
    task automatic send_sym(input logic b);
        if (b) begin
            hold(1'b1, LONG_CYC);
            hold(1'b0, SHORT_CYC);
        end else begin
            hold(1'b1, SHORT_CYC);
            hold(1'b0, LONG_CYC);
        end
    endtask

    // Six-symbol entry pattern, leftmost symbol first
    task automatic send_entry(input logic [5:0] pat);
        for (int i = 5; i >= 0; i--) begin
            send_sym(pat[i]);
        end
    endtask

    // Word write: address code, then payload in inverted polarity
    task automatic send_word(input logic [2:0] adr, input logic [7:0] wd);
        for (int i = 0; i < 3; i++) begin
            send_sym(adr[i]);
        end
        for (int k = 0; k < 8; k++) begin
            send_sym(~wd[k]);
        end
    endtask

    // Jump command: address code of all ones, then the raw code symbols
    task automatic send_jump(input logic [7:0] code);
        for (int i = 0; i < 3; i++) begin
            send_sym(1'b1);
        end
        for (int k = 7; k >= 0; k--) begin
            send_sym(code[k]);
        end
    endtask

    // Plain clock pulse while in readback
    task automatic rb_clock();
        hold(1'b1, RB_HALF);
        hold(1'b0, RB_HALF);
    endtask
endmodule
`default_nettype wire

// ---- test_pwcl_link.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_pwcl_link;
    import pwcl_pkg::*;
    // Short time-out, still longer than any legal pulse
    localparam int TO_CYC = 5000;
    // Store model settles in one clock, so the host wait is shortened
    localparam int STORE_WAIT_CYC = 2500;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clock;
    logic rst_n;
    logic cePin;
    logic pllClk;
    logic progPin;
    logic clkOutPin;
    logic lvdsOe_n;
    logic eclOe_n;
    logic powerDown;
    logic [47:0] cfgRam;
    pwcl_mode_type linkMode;
    int errTotal;
    int checked;

    pwcl_host_model i_pwcl_host_model (
        .clock(clock),
        .progPin(progPin)
    );

    pwcl_link #(.TIMEOUT_CYC(TO_CYC)) i_pwcl_link (
        .clock(clock),
        .rst_n(rst_n),
        .progPin(progPin),
        .cePin(cePin),
        .pllClk(pllClk),
        .clkOutPin(clkOutPin),
        .lvdsOe_n(lvdsOe_n),
        .eclOe_n(eclOe_n),
        .powerDown(powerDown),
        .cfgRam(cfgRam),
        .linkMode(linkMode)
    );

    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Bounded wait for a mode; giving up ends the run
    task automatic wait_mode(input pwcl_mode_type m, input int limit);
        for (int i = 0; i < limit && linkMode !== m; i++) begin
            step(1);
        end
        check(48'(linkMode), 48'(m));
        if (linkMode !== m) begin
            end_of_test();
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Chip enable drives power-down and the selected driver
    task automatic test_power();
        cePin = 1'b0;
        pllClk = 1'b1;
        step(6);
        check(48'(powerDown), 48'h1);
        check(48'({lvdsOe_n, eclOe_n}), 48'h3);
        cePin = 1'b1;
        step(6);
        check(48'(powerDown), 48'h0);
        check(48'({lvdsOe_n, eclOe_n}), 48'h1);
        check(48'(clkOutPin), 48'h1);
        pllClk = 1'b0;
        step(6);
        check(48'(clkOutPin), 48'h0);
        // Enable stays high three symbol periods before symbols
        step(3 * i_pwcl_host_model.SYM_CYC);
        $display("test power done");
    endtask

    // A long low in mid-pattern discards the symbols before it
    task automatic test_timeout();
        for (int i = 0; i < 4; i++) begin
            i_pwcl_host_model.send_sym(PAT_READBACK[5 - i]);
        end
        i_pwcl_host_model.hold(1'b0, TO_CYC + 100);
        i_pwcl_host_model.send_sym(1'b1);
        i_pwcl_host_model.send_sym(1'b1);
        step(20);
        check(48'(linkMode), 48'(M_NORMAL));
        check(cfgRam, 48'h0);
        $display("test timeout done");
    endtask

    // Readback of the locked store image, ignoring chip enable meanwhile
    task automatic test_readback();
        logic exp;
        pllClk = 1'b1;
        i_pwcl_host_model.send_entry(PAT_READBACK);
        wait_mode(M_READBACK, 100);
        cePin = 1'b0;
        i_pwcl_host_model.rb_clock();
        check(48'(powerDown), 48'h0);
        for (int i = 0; i < RB_BITS; i++) begin
            // Written and lock flags set, word0 payload bit 6 sent MSB first
            exp = (i < 3) ? REV_ID[2 - i] : (i == 9 || i == 10 || i == 52);
            i_pwcl_host_model.rb_clock();
            check(48'(clkOutPin), 48'(exp));
        end
        check(48'(linkMode), 48'(M_READBACK));
        i_pwcl_host_model.rb_clock();
        check(48'(linkMode), 48'(M_NORMAL));
        cePin = 1'b1;
        step(6);
        check(48'(clkOutPin), 48'h1);
        $display("test readback done");
    endtask

    // Entry, then a word write that selects the emitter driver
    task automatic test_prog();
        i_pwcl_host_model.send_entry(PAT_PROG);
        wait_mode(M_PROG, 100);
        cePin = 1'b0;
        step(6);
        check(48'(powerDown), 48'h0);
        // Payload bit 6 is the driver select field
        i_pwcl_host_model.send_word(3'h0, 8'h40);
        step(4);
        check(cfgRam, 48'h40);
        check(48'(linkMode), 48'(M_PROG));
        step(6);
        check(48'({lvdsOe_n, eclOe_n}), 48'h2);
        cePin = 1'b1;
        $display("test prog done");
    endtask

    // Locked store of the RAM copy, then the exit jump
    task automatic test_store();
        i_pwcl_host_model.send_jump(JUMP_STORE_LOCK);
        wait_mode(M_STORE_LOCK, 100);
        cePin = 1'b0;
        step(6);
        check(48'(powerDown), 48'h0);
        step(STORE_WAIT_CYC);
        i_pwcl_host_model.send_jump(JUMP_EXIT);
        wait_mode(M_NORMAL, 100);
        check(cfgRam, 48'h40);
        cePin = 1'b1;
        step(6);
        check(48'(powerDown), 48'h0);
        $display("test store done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        errTotal = 0;
        checked = 0;
        rst_n = 1'b0;
        cePin = 1'b0;
        pllClk = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        rst_n = 1'b1;
        step(2);
        test_power();
        test_timeout();
        test_prog();
        test_store();
        test_readback();
        end_of_test();
    end
endmodule
`default_nettype wire
